/* hub_ctrl_pkg.sv */
// Shared constants and types for the hub port control block
package hub_ctrl_pkg;
  localparam int num_ports = 4;
  localparam int id_width = 16;
  localparam int cfg_words = 4;
  localparam logic [1:0] cfg_addr_reset = 2'h0;
  localparam logic [1:0] cfg_addr_last = 2'h3;
  localparam logic [6:0] address_reset = 7'h00;
  localparam logic [7:0] config_value_reset = 8'h00;
  localparam logic [3:0] status_endpoint = 4'h1;
  localparam int clock_hz = 20000000;
  localparam int reset_time_us = 10;
  localparam int reset_cycles = (reset_time_us * (clock_hz / 1000000));
  localparam int chirp_time_us = 1000;
  localparam int chirp_cycles = (chirp_time_us * (clock_hz / 1000000));
  localparam logic [15:0] reset_count_reset = 16'h0000;

  typedef enum logic [4:0] {
    hub_fetch = 5'h01,
    hub_wait_power = 5'h02,
    hub_wait_reset = 5'h04,
    hub_chirp = 5'h08,
    hub_run = 5'h10
  } hub_state_type;

  typedef enum logic [5:0] {
    port_off = 6'h01,
    port_disconnected = 6'h02,
    port_resetting = 6'h04,
    port_enabled = 6'h08,
    port_suspended = 6'h10,
    port_disabled = 6'h20
  } port_state_type;

  typedef struct packed {
    logic set_power;
    logic set_reset;
    logic clear_enable;
    logic set_suspend;
    logic clear_suspend;
    logic [1:0] port;
  } port_request_type;

  typedef struct packed {
    logic connected;
    logic high_speed;
    logic low_speed;
    logic line_active;
    logic after_eof2;
    logic wakeup;
  } port_line_type;

  typedef struct packed {
    logic [3:0] port;
    logic [3:0] endpoint;
  } change_report_type;

  function automatic logic [3:0] port_bit(input logic [1:0] p);
    port_bit = 4'h1 << p;
  endfunction
endpackage

/* usb_hub_port_control.sv */
// Hub-level control: configuration fetch, attach, enumeration and port handling
`timescale 1ns/1ps
//
// Overview of operation
// - At power up fetch configuration words from the serial EEPROM before attaching.
// - After fetch, connect D+ pull-up only while bus power sensed, then await reset.
// - During upstream bus reset, send high-speed capable chirp.
// - Host chirp answer enters high-speed mode and drops D+ pull-up.
// - Without host chirp answer, stay a full-speed legacy hub.
// - Every bus reset clears address and configuration value to zero.
// - Full hub function withheld until host configures the hub.
// - Four downstream ports, each marked usable or removable by configuration.
// - Before configuration, ports held in SE0 and unpowered.
// - After configuration stop driving ports; host powers each port individually.
// - Detect connect and disconnect, report changes through endpoint 1.
// - Port reset with device attached enables port, lights green, arms babble.
// - Non-idle line after EOF2 on enabled port is babble, disabling port.
// - Clear enable request disables the addressed port.
// - Suspend request suspends only the addressed port.
// - Wakeup on suspended port while hub awake gives a change report.
// - Wakeup on suspended port while hub suspended is forwarded upstream.
// - Clear suspend request resumes the addressed suspended port.
// - At high speed, full/low-speed port traffic routes via the translator.
// - At high speed, high-speed port traffic routes via the repeater only.
// - At full speed, high-speed devices run at full speed, others normal.
// - Repeater upstream path blocks downstream babble and disconnect propagation.
module usb_hub_port_control (
  input wire logic mclk,
  input wire logic srst,
  output logic eeprom_read,
  output logic [1:0] eeprom_addr,
  input wire logic eeprom_valid,
  input wire logic [hub_ctrl_pkg::id_width-1:0] eeprom_data,
  output logic [hub_ctrl_pkg::id_width-1:0] vendor_identifier,
  output logic [hub_ctrl_pkg::id_width-1:0] product_identifier,
  output logic [hub_ctrl_pkg::id_width-1:0] device_revision_identifier,
  output logic [3:0] port_usable,
  output logic [3:0] port_removable,
  input wire logic upstream_bus_power_sense,
  input wire logic upstream_bus_reset,
  input wire logic host_chirp,
  input wire logic hub_suspended,
  output logic dplus_pullup,
  output logic chirp_out,
  output logic high_speed_mode,
  input wire logic set_address,
  input wire logic set_configuration,
  input wire logic [7:0] setup_value,
  output logic [6:0] device_address,
  output logic [7:0] config_value,
  output logic configured,
  input wire logic request_valid,
  input wire hub_ctrl_pkg::port_request_type request,
  input wire hub_ctrl_pkg::port_line_type port_line [hub_ctrl_pkg::num_ports],
  input wire logic repeater_upstream,
  output logic [3:0] port_power,
  output logic [3:0] port_drive_se0,
  output logic [3:0] port_reset_out,
  output logic [3:0] port_enable,
  output logic [3:0] port_suspend,
  output logic [3:0] green_led,
  input wire logic [3:0] indicator_override,
  output logic [3:0] route_translator,
  output logic [3:0] route_repeater,
  output logic [3:0] port_full_speed,
  output logic [3:0] block_upstream,
  output logic remote_wakeup_up,
  output logic report_valid,
  input wire logic report_ready,
  output hub_ctrl_pkg::change_report_type report
);
  import hub_ctrl_pkg::*;

  hub_state_type hub_state;
  port_state_type port_state [num_ports];
  logic power_s1, power_s2, reset_s1, reset_s2, reset_s3, chirp_s1, chirp_s2;
  logic front_ptr;
  change_report_type incoming;
  logic [15:0] chirp_count;
  logic [3:0] changes;
  logic [3:0] babble;
  logic [3:0] was_connected;
  change_report_type buf_data [2];
  logic [1:0] buf_full;
  logic buf_wr, buf_rd;
  logic wr_ptr, rd_ptr;
  logic [3:0] req_bit;

  assign req_bit = port_bit(request.port);

  // Pin synchronisers
  always_ff @(posedge mclk)
  begin
    power_s1 <= upstream_bus_power_sense;
    power_s2 <= power_s1;
    reset_s1 <= upstream_bus_reset;
    reset_s2 <= reset_s1;
    reset_s3 <= reset_s2;
    chirp_s1 <= host_chirp;
    chirp_s2 <= chirp_s1;
  end

  // Configuration fetch
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      eeprom_read <= 1'b1;
      eeprom_addr <= cfg_addr_reset;
      vendor_identifier <= '0;
      product_identifier <= '0;
      device_revision_identifier <= '0;
      port_usable <= 4'h0;
      port_removable <= 4'h0;
    end
    else if (hub_state == hub_fetch && eeprom_valid)
    begin
      case (eeprom_addr)
        2'h0: vendor_identifier <= eeprom_data;
        2'h1: product_identifier <= eeprom_data;
        2'h2: device_revision_identifier <= eeprom_data;
        default:
        begin
          port_usable <= eeprom_data[3:0];
          port_removable <= eeprom_data[7:4];
        end
      endcase
      eeprom_addr <= eeprom_addr + 2'h1;
      if (eeprom_addr == cfg_addr_last)
        eeprom_read <= 1'b0;
    end
  end

  // Upstream attach and speed negotiation
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      hub_state <= hub_fetch;
      dplus_pullup <= 1'b0;
      chirp_out <= 1'b0;
      high_speed_mode <= 1'b0;
      chirp_count <= reset_count_reset;
    end
    else
    begin
      case (hub_state)
        hub_fetch:
          if (eeprom_valid && eeprom_addr == cfg_addr_last)
            hub_state <= hub_wait_power;
        hub_wait_power:
          if (power_s2)
          begin
            dplus_pullup <= 1'b1;
            hub_state <= hub_wait_reset;
          end
        hub_wait_reset:
          if (!power_s2)
          begin
            dplus_pullup <= 1'b0;
            hub_state <= hub_wait_power;
          end
          else if (reset_s2)
          begin
            chirp_out <= 1'b1;
            chirp_count <= reset_count_reset;
            high_speed_mode <= 1'b0;
            hub_state <= hub_chirp;
          end
        hub_chirp:
        begin
          chirp_count <= chirp_count + 16'h0001;
          if (!power_s2)
          begin
            chirp_out <= 1'b0;
            dplus_pullup <= 1'b0;
            hub_state <= hub_wait_power;
          end
          else if (chirp_s2)
          begin
            chirp_out <= 1'b0;
            high_speed_mode <= 1'b1;
            dplus_pullup <= 1'b0;
            hub_state <= hub_run;
          end
          else if (!reset_s2 || chirp_count == 16'(chirp_cycles))
          begin
            chirp_out <= 1'b0;
            high_speed_mode <= 1'b0;
            hub_state <= hub_run;
          end
        end
        hub_run:
          if (!power_s2)
          begin
            dplus_pullup <= 1'b0;
            high_speed_mode <= 1'b0;
            hub_state <= hub_wait_power;
          end
          else if (reset_s2 && !reset_s3)
          begin
            dplus_pullup <= 1'b1;
            high_speed_mode <= 1'b0;
            chirp_out <= 1'b1;
            chirp_count <= reset_count_reset;
            hub_state <= hub_chirp;
          end
        default:
          hub_state <= hub_fetch;
      endcase
    end
  end

  // Enumeration state
  always_ff @(posedge mclk)
  begin
    if (srst || reset_s2)
    begin
      device_address <= address_reset;
      config_value <= config_value_reset;
      configured <= 1'b0;
    end
    else if (hub_state == hub_run)
    begin
      if (set_address)
        device_address <= setup_value[6:0];
      if (set_configuration)
      begin
        config_value <= setup_value;
        configured <= (setup_value != config_value_reset);
      end
    end
  end

  // Per-port state machines
  genvar g;
  generate
    for (g = 0; g < num_ports; g++)
    begin : ports
      always_ff @(posedge mclk)
      begin
        if (srst || !configured || !port_usable[g])
        begin
          port_state[g] <= port_off;
          port_power[g] <= 1'b0;
          port_drive_se0[g] <= srst || !configured;
          port_reset_out[g] <= 1'b0;
          babble[g] <= 1'b0;
        end
        else
        begin
          port_drive_se0[g] <= 1'b0;
          babble[g] <= 1'b0;
          case (port_state[g])
            port_off:
              if (request_valid && request.set_power && req_bit[g])
              begin
                port_power[g] <= 1'b1;
                port_state[g] <= port_disconnected;
              end
            port_disconnected:
              if (request_valid && request.set_reset && req_bit[g] && port_line[g].connected)
              begin
                port_reset_out[g] <= 1'b1;
                port_state[g] <= port_resetting;
              end
            port_resetting:
            begin
              port_reset_out[g] <= 1'b0;
              port_state[g] <= port_enabled;
            end
            port_enabled:
              if (!port_line[g].connected)
                port_state[g] <= port_disconnected;
              else if (port_line[g].line_active && port_line[g].after_eof2)
              begin
                babble[g] <= 1'b1;
                port_state[g] <= port_disabled;
              end
              else if (request_valid && request.clear_enable && req_bit[g])
                port_state[g] <= port_disabled;
              else if (request_valid && request.set_suspend && req_bit[g])
                port_state[g] <= port_suspended;
            port_suspended:
              if (!port_line[g].connected)
                port_state[g] <= port_disconnected;
              else if (port_line[g].wakeup)
                port_state[g] <= port_enabled;
              else if (request_valid && request.clear_suspend && req_bit[g])
                port_state[g] <= port_enabled;
            port_disabled:
              if (!port_line[g].connected)
                port_state[g] <= port_disconnected;
              else if (request_valid && request.set_reset && req_bit[g])
              begin
                port_reset_out[g] <= 1'b1;
                port_state[g] <= port_resetting;
              end
            default:
              port_state[g] <= port_off;
          endcase
        end
      end

      // Outputs derived from port state, speed mode and line status
      always_ff @(posedge mclk)
      begin
        if (srst)
        begin
          port_enable[g] <= 1'b0;
          port_suspend[g] <= 1'b0;
          green_led[g] <= 1'b0;
          route_translator[g] <= 1'b0;
          route_repeater[g] <= 1'b0;
          port_full_speed[g] <= 1'b0;
          block_upstream[g] <= 1'b0;
          was_connected[g] <= 1'b0;
        end
        else
        begin
          port_enable[g] <= (port_state[g] == port_enabled);
          port_suspend[g] <= (port_state[g] == port_suspended);
          green_led[g] <= (port_state[g] == port_enabled) && !indicator_override[g];
          route_translator[g] <= high_speed_mode && !port_line[g].high_speed;
          route_repeater[g] <= !high_speed_mode || port_line[g].high_speed;
          port_full_speed[g] <= !port_line[g].low_speed &&
            (!high_speed_mode || !port_line[g].high_speed);
          block_upstream[g] <= repeater_upstream && (babble[g] || !port_line[g].connected);
          was_connected[g] <= port_power[g] && port_line[g].connected;
        end
      end
    end
  endgenerate

  // Change collection: set wins over clear
  logic [3:0] events;
  logic [3:0] wake_events;
  always_comb
  begin
    events = 4'h0;
    wake_events = 4'h0;
    for (int i = 0; i < num_ports; i++)
    begin
      if (port_power[i] && (port_line[i].connected != was_connected[i]))
        events[i] = 1'b1;
      if (babble[i] || (port_state[i] == port_resetting))
        events[i] = 1'b1;
      if (port_state[i] == port_suspended && port_line[i].wakeup)
        wake_events[i] = 1'b1;
    end
  end

  assign buf_wr = (changes != 4'h0) && (buf_full != 2'h2);
  assign buf_rd = report_valid && report_ready;
  assign front_ptr = buf_rd ? ~rd_ptr : rd_ptr;
  assign incoming = '{port: changes, endpoint: status_endpoint};

  always_ff @(posedge mclk)
  begin
    if (srst)
      changes <= 4'h0;
    else
      changes <= (buf_wr ? 4'h0 : changes) | events | (hub_suspended ? 4'h0 : wake_events);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      remote_wakeup_up <= 1'b0;
    else
      remote_wakeup_up <= hub_suspended && (remote_wakeup_up || wake_events != 4'h0);
  end

  // Two-entry buffer toward the status change endpoint
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      buf_full <= 2'h0;
      buf_data[0] <= '0;
      buf_data[1] <= '0;
    end
    else
    begin
      if (buf_wr)
      begin
        buf_data[wr_ptr] <= incoming;
        wr_ptr <= ~wr_ptr;
      end
      if (buf_rd)
        rd_ptr <= ~rd_ptr;
      buf_full <= buf_full + {1'b0, buf_wr} - {1'b0, buf_rd};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      report_valid <= 1'b0;
      report <= '0;
    end
    else
    begin
      report_valid <= (buf_full + {1'b0, buf_wr} - {1'b0, buf_rd}) != 2'h0;
      // Bypass so the word shown with a rising valid is the one just written
      report <= (buf_wr && wr_ptr == front_ptr) ? incoming : buf_data[front_ptr];
    end
  end
endmodule

/* hub_port_control_monitor.sv */
// Concurrent checks on the hub port control ports
`timescale 1ns/1ps
module hub_port_control_monitor (
  input wire logic mclk,
  input wire logic srst,
  input wire logic eeprom_read,
  input wire logic upstream_bus_power_sense,
  input wire logic upstream_bus_reset,
  input wire logic hub_suspended,
  input wire logic dplus_pullup,
  input wire logic high_speed_mode,
  input wire logic [6:0] device_address,
  input wire logic [7:0] config_value,
  input wire logic configured,
  input wire hub_ctrl_pkg::port_line_type port_line [hub_ctrl_pkg::num_ports],
  input wire logic [3:0] port_power,
  input wire logic [3:0] port_drive_se0,
  input wire logic [3:0] port_enable,
  input wire logic [3:0] port_suspend,
  input wire logic [3:0] route_translator,
  input wire logic [3:0] route_repeater,
  input wire logic remote_wakeup_up,
  input wire logic report_valid,
  input wire logic report_ready,
  input wire hub_ctrl_pkg::change_report_type report
);
  import hub_ctrl_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_babble0;
    port_enable[0] && port_line[0].line_active && port_line[0].after_eof2;
  endsequence
  sequence s_hidden_wake1;
    hub_suspended && port_suspend[1] && port_line[1].wakeup;
  endsequence
  AST_FETCH_DETACHED: assert property (eeprom_read |-> !dplus_pullup)
    else $error("pull-up on during fetch");
  AST_PULLUP_SENSE: assert property ((!upstream_bus_power_sense)[*4] |-> !dplus_pullup)
    else $error("pull-up on without bus power");
  AST_HS_RELEASE: assert property (high_speed_mode |-> !dplus_pullup)
    else $error("pull-up on in high speed");
  AST_BUS_RESET_CLEAR: assert property (upstream_bus_reset[*4] |->
    config_value == config_value_reset && device_address == address_reset && !configured)
    else $error("enumeration kept over bus reset");
  AST_CONFIG_GATE: assert property (configured |-> config_value != config_value_reset)
    else $error("configured with zero value");
  AST_UNCONFIG_SE0: assert property ((!configured)[*3] |->
    port_drive_se0 == 4'hf && port_power == 4'h0)
    else $error("ports not held while unconfigured");
  AST_CONFIG_RELEASE: assert property (configured[*3] |-> port_drive_se0 == 4'h0)
    else $error("ports driven after configuration");
  AST_REPORT_HOLD: assert property (report_valid && !report_ready |=>
    report_valid && $stable(report))
    else $error("report dropped while stalled");
  AST_REPORT_EP: assert property (report_valid |-> report.endpoint == status_endpoint)
    else $error("report on wrong endpoint");
  AST_BABBLE_OFF: assert property (s_babble0 |-> ##[1:4] !port_enable[0])
    else $error("babbling port left enabled");
  AST_ROUTE_SPLIT: assert property ((route_translator & route_repeater) == 4'h0)
    else $error("port routed two ways");
  AST_FS_NO_TRANSLATOR: assert property ((!high_speed_mode)[*3] |-> route_translator == 4'h0)
    else $error("translator used at full speed");
  AST_WAKE_FORWARD: assert property (s_hidden_wake1 |-> ##[1:4] remote_wakeup_up)
    else $error("wakeup not forwarded");
endmodule
bind usb_hub_port_control hub_port_control_monitor u_monitor (.mclk, .srst, .eeprom_read,
  .upstream_bus_power_sense, .upstream_bus_reset, .hub_suspended, .dplus_pullup,
  .high_speed_mode, .device_address, .config_value, .configured, .port_line, .port_power,
  .port_drive_se0, .port_enable, .port_suspend, .route_translator, .route_repeater,
  .remote_wakeup_up, .report_valid, .report_ready, .report);

/* cfg_memory_model.sv */
// Configuration memory model answering word fetches after a set lag
`timescale 1ns/1ps
module cfg_memory_model #(
  parameter logic [63:0] image = 64'h0
) (
  input wire logic mclk,
  input wire logic [3:0] lag,
  input wire logic eeprom_read,
  input wire logic [1:0] eeprom_addr,
  output logic eeprom_valid,
  output logic [15:0] eeprom_data
);
  int waited = 0;
  initial
  begin
    eeprom_valid = 1'b0;
    eeprom_data = 16'h0000;
  end
  // Data means nothing outside the valid cycle, so it shows the inverse there
  always @(posedge mclk)
  begin
    if (eeprom_valid || !eeprom_read)
    begin
      eeprom_valid <= 1'b0;
      eeprom_data <= ~eeprom_data;
      waited <= 0;
    end
    else if (waited >= lag)
    begin
      eeprom_valid <= 1'b1;
      eeprom_data <= image[16 * eeprom_addr +: 16];
    end
    else
      waited <= waited + 1;
  end
endmodule

/* usb_hub_port_control_tb_top.sv */
// Self-checking bench for the hub port control block
`timescale 1ns/1ps
module usb_hub_port_control_tb_top;
  import hub_ctrl_pkg::*;
  // Identifier words are arbitrary; word 3 marks ports 0, 1 and 3 usable
  localparam logic [63:0] rom_image = 64'h00db_0102_3c4d_1a2b;
  typedef struct packed {
    port_request_type req;
    logic [3:0] power;
    logic [3:0] enable;
    logic [3:0] suspend;
  } step_type;
  logic mclk = 1'b0, srst = 1'b1, eeprom_read, eeprom_valid, configured, dplus_pullup;
  logic upstream_bus_power_sense = 1'b0, upstream_bus_reset = 1'b0, host_chirp = 1'b0;
  logic hub_suspended = 1'b0, set_address = 1'b0, set_configuration = 1'b0;
  logic request_valid = 1'b0, report_ready = 1'b1, repeater_upstream = 1'b1;
  logic chirp_out, high_speed_mode, remote_wakeup_up, report_valid;
  logic [1:0] eeprom_addr;
  logic [15:0] eeprom_data, vendor_identifier, product_identifier, device_revision_identifier;
  logic [6:0] device_address;
  logic [7:0] config_value, setup_value = 8'h00;
  logic [3:0] indicator_override = 4'h0, lag = 4'h3, port_usable, port_removable, port_power;
  logic [3:0] port_drive_se0, port_reset_out, port_enable, port_suspend, green_led;
  logic [3:0] route_translator, route_repeater, port_full_speed, block_upstream;
  port_request_type request = '0;
  port_line_type port_line [num_ports] = '{default: '0};
  change_report_type report;
  int n_mismatch = 0, samples_checked = 0, i;
  step_type steps [9] = '{'{7'h40, 4'h1, 4'h0, 4'h0}, '{7'h41, 4'h3, 4'h0, 4'h0},
    '{7'h42, 4'h3, 4'h0, 4'h0}, '{7'h43, 4'hb, 4'h0, 4'h0}, '{7'h20, 4'hb, 4'h1, 4'h0},
    '{7'h21, 4'hb, 4'h3, 4'h0}, '{7'h23, 4'hb, 4'h3, 4'h0}, '{7'h09, 4'hb, 4'h1, 4'h2},
    '{7'h05, 4'hb, 4'h3, 4'h0}};

  usb_hub_port_control dut (.mclk, .srst, .eeprom_read, .eeprom_addr, .eeprom_valid,
    .eeprom_data, .vendor_identifier, .product_identifier, .device_revision_identifier,
    .port_usable, .port_removable, .upstream_bus_power_sense, .upstream_bus_reset,
    .host_chirp, .hub_suspended, .dplus_pullup, .chirp_out, .high_speed_mode, .set_address,
    .set_configuration, .setup_value, .device_address, .config_value, .configured,
    .request_valid, .request, .port_line, .repeater_upstream, .port_power, .port_drive_se0,
    .port_reset_out, .port_enable, .port_suspend, .green_led, .indicator_override,
    .route_translator, .route_repeater, .port_full_speed, .block_upstream,
    .remote_wakeup_up, .report_valid, .report_ready, .report);
  cfg_memory_model #(.image(rom_image)) memory (.mclk, .lag, .eeprom_read, .eeprom_addr,
    .eeprom_valid, .eeprom_data);

  always #25 mclk = ~mclk;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic close_out();
    $display("checked %0d, mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic send(input port_request_type req);
    request = req;
    request_valid = 1'b1;
    tick(1);
    request_valid = 1'b0;
    tick(4);
  endtask
  task automatic do_reset();
    srst = 1'b1;
    tick(20);
    srst = 1'b0;
    tick(2);
    check("fetching", 1, eeprom_read);
    check("se0", 4'hf, port_drive_se0);
    for (i = 0; i < 200 && eeprom_read !== 1'b0; i++)
      tick(1);
    check("vendor", rom_image[15:0], vendor_identifier);
    check("product", rom_image[31:16], product_identifier);
    check("revision", rom_image[47:32], device_revision_identifier);
    check("usable", rom_image[51:48], port_usable);
    check("removable", rom_image[55:52], port_removable);
    check("pullup", 0, dplus_pullup);
    done("reset and fetch");
  endtask
  task automatic attach(input logic hs);
    upstream_bus_power_sense = 1'b1;
    for (i = 0; i < 50 && dplus_pullup !== 1'b1; i++)
      tick(1);
    check("pullup", 1, dplus_pullup);
    upstream_bus_reset = 1'b1;
    for (i = 0; i < 1000 && chirp_out !== 1'b1; i++)
      tick(1);
    check("chirp", 1, chirp_out);
    host_chirp = hs;
    for (i = 0; i < chirp_cycles + 500 && chirp_out !== 1'b0; i++)
      tick(1);
    host_chirp = 1'b0;
    upstream_bus_reset = 1'b0;
    tick(5);
    check("speed", hs, high_speed_mode);
    check("pullup", !hs, dplus_pullup);
    done("attach");
  endtask
  task automatic enumerate();
    send(7'h40);
    check("power", 0, port_power);
    setup_value = 8'h2a;
    set_address = 1'b1;
    tick(1);
    set_address = 1'b0;
    setup_value = 8'h01;
    set_configuration = 1'b1;
    tick(1);
    set_configuration = 1'b0;
    tick(4);
    check("address", 7'h2a, device_address);
    check("config", 8'h01, config_value);
    check("se0", 0, port_drive_se0);
    done("enumerate");
  endtask

  initial
  begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    do_reset();
    attach(1'b1);
    port_line[0].connected = 1'b1;
    port_line[1].connected = 1'b1;
    port_line[1].high_speed = 1'b1;
    enumerate();
    for (int r = 0; r < 9; r++)
    begin
      send(steps[r].req);
      check("power", steps[r].power, port_power);
      check("enable", steps[r].enable, port_enable & ~port_suspend);
      check("suspend", steps[r].suspend, port_suspend);
    end
    check("translator", 4'hd, route_translator);
    check("full speed", 4'hd, port_full_speed);
    check("repeater", 4'h2, route_repeater);
    check("green", 4'h3, green_led);
    tick(10);
    report_ready = 1'b0;
    port_line[3].connected = 1'b1;
    tick(8);
    check("report port", 4'h8, report.port & {4{report_valid}});
    check("endpoint", status_endpoint, report.endpoint);
    report_ready = 1'b1;
    tick(8);
    check("report drained", 0, report_valid);
    for (int h = 0; h < 2; h++)
    begin
      send(7'h09);
      report_ready = 1'b0;
      hub_suspended = h[0];
      port_line[1].wakeup = 1'b1;
      tick(6);
      if (h == 1)
        check("wakeup up", 1, remote_wakeup_up);
      else
        check("wakeup report", 4'h2, report.port & {4{report_valid}});
      port_line[1].wakeup = 1'b0;
      hub_suspended = 1'b0;
      report_ready = 1'b1;
      tick(10);
    end
    port_line[0].line_active = 1'b1;
    port_line[0].after_eof2 = 1'b1;
    tick(5);
    check("babble", 0, port_enable[0]);
    port_line[0] = '0;
    send(7'h11);
    check("clear enable", 0, port_enable[1]);
    check("block", 4'h5, block_upstream);
    upstream_bus_reset = 1'b1;
    tick(8);
    check("config", 0, config_value);
    check("address", 0, device_address);
    check("power", 0, port_power);
    upstream_bus_reset = 1'b0;
    done("port handling");
    lag = 4'h9;
    port_line = '{default: '0};
    port_line[0].connected = 1'b1;
    port_line[0].high_speed = 1'b1;
    do_reset();
    attach(1'b0);
    enumerate();
    send(7'h40);
    send(7'h20);
    check("full speed", 1, port_full_speed[0]);
    check("translator", 0, route_translator);
    repeater_upstream = 1'b0;
    tick(2);
    check("block", 0, block_upstream);
    done("full speed hub");
    close_out();
  end
endmodule
